//--- hdl/adc_result_pkg.sv
// Package: register map, field layout and register-bus carriers for the conversion result registers
package adc_result_pkg;
    // Register byte addresses
    localparam logic [7:0] pair2_low_addr = 8'h64;
    localparam logic [7:0] pair2_high_addr = 8'h65;
    localparam logic [7:0] pair3_low_addr = 8'h66;
    localparam logic [7:0] pair3_high_addr = 8'h67;
    localparam logic [7:0] irq_status_addr = 8'h68;
    localparam logic [7:0] irq_mask_addr = 8'h69;

    // Result and field layout
    localparam int result_width = 10;
    localparam int num_pairs = 2;
    localparam int first_pair = 2;
    localparam logic [4:0] low_fill_ones = 5'h1f;
    localparam logic [7:0] unmapped_value = 8'h00;
    localparam logic [num_pairs-1:0] flags_reset = 2'h0;
    localparam logic [num_pairs-1:0] mask_reset = 2'h0;
    localparam logic [result_width-1:0] result_reset = 10'h000;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    // Conversion result delivery
    typedef struct packed {
        logic valid;
        logic [0:0] pair;
        logic [result_width-1:0] value;
    } conv_result_s;
endpackage

//--- hdl/result_slot.sv
// One channel pair's result storage and its stored-result flag
`timescale 1ns/100ps
module result_slot
    import adc_result_pkg::*;
#(
    parameter int width = result_width
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Converter side
    input wire logic load,
    input wire logic [width-1:0] value,
    // Software side
    input wire logic read_hit,
    // Stored state
    output logic [width-1:0] result,
    output logic stored_result_flag
);
    initial begin
        if (width != result_width) begin
            $error("result_slot supports only the documented result width");
        end
    end

    // Result storage; a new conversion overwrites an unread one
    // overwrite unread result
    always_ff @(posedge clk) begin
        if (srst) begin
            result <= result_reset;
        end else if (load) begin
            result <= value;
        end
    end

    // Flag: load wins over a read in the same cycle so no result goes unnoticed
    // set on store
    always_ff @(posedge clk) begin
        if (srst) begin
            stored_result_flag <= 1'b0;
        end else if (load) begin
            stored_result_flag <= 1'b1;
        end else if (read_hit) begin
            stored_result_flag <= 1'b0;
        end
    end
endmodule

//--- hdl/adc_result_registers.sv
// Conversion result registers for channel pairs 2/6 and 3/7 with store-event interrupt
// What this block does
// - Low byte bits five to one always read as one.
// - Low byte bit zero shows the channel's stored-unread result flag.
// - Converter writing a channel's result sets that channel's flag.
// - Software reading either byte of a channel clears its flag.
// - Upper eight bits in high byte, low two in low bits 7:6; read-only.
`timescale 1ns/100ps
module adc_result_registers
    import adc_result_pkg::*;
#(
    parameter int pairs = num_pairs
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Converter result delivery
    input wire conv_result_s conv,
    // Register bus
    input wire bus_req_s bus,
    output logic [7:0] rdata,
    // Interrupt
    output logic irq
);
    // Timing seen from software:
    //   edge n   : read strobe and address taken, read data registered
    //   edge n+1 : read data stands for this one cycle only, then drops to zero
    //   the stored-result flag of the pair read is cleared at edge n as well
    // Timing seen from the converter:
    //   edge m   : valid pulse taken, result and flag stored, status bit set
    //   edge m+1 : interrupt line follows the status bit through the mask
    // Hazards handled here:
    //   a store and a read of the same pair in one cycle leave the flag set,
    //   so a result that lands while software reads is never lost silently;
    //   a store and a write-one clear of the same status bit leave it set too;
    //   a newer store overwrites an unread result; software learns of it only
    //   through the flag it sees, so a missed result cannot be detected here.
    // Limitation: the byte map is fixed, so only two pairs and ten-bit results fit.

    // Register map, all bytes on the one register bus:
    //   pair 2/6 low byte  : result bits one and zero, five fixed ones, stored flag
    //   pair 2/6 high byte : result bits nine down to two
    //   pair 3/7 low byte  : same layout as the pair 2/6 low byte
    //   pair 3/7 high byte : same layout as the pair 2/6 high byte
    //   status byte        : one sticky store event per pair, write one to clear
    //   mask byte          : one enable per pair, read and write
    // Result bytes are read-only; a write to them has no effect at all.
    // Any other address reads as zero and ignores writes.
    // Status bit zero is pair 2/6 and bit one is pair 3/7, likewise in the mask.
    // The stored flag and the status bit are kept apart on purpose: reading a
    // result clears the flag, while the status bit stays until software clears it,
    // so a handler may read results before it acknowledges the event.

    // Notes for integration:
    //   the bus never waits; read data is always ready one cycle after the strobe
    //   read data is zero outside that cycle, so it may be ored with other slaves
    //   a read of a result byte is not free of side effects: it clears the flag,
    //   so a debugger that reads the bytes will hide a pending result
    //   a read of the status or mask byte has no side effect
    //   results read back as zero after reset until the first store, but software
    //   should treat them as undefined until the flag has been seen set
    //   the converter may deliver a result in any cycle, back to back as well
    //   the interrupt is a level; it falls one cycle after the cause is cleared
    //   the status byte records events even while they are masked, so unmasking
    //   later raises the interrupt for an event that is already waiting

    // Byte layout derived from the bus and result widths
    localparam int byte_bits = $bits(rdata);
    localparam int low_result_bits = result_width - byte_bits;
    localparam int fill_bits = $bits(low_fill_ones);
    localparam int flag_bits = 1;
    localparam int status_pad = byte_bits - pairs;

    // Elaboration checks; the register map leaves no room for other shapes
    initial begin
        if (pairs != num_pairs) begin
            $error("adc_result_registers supports exactly two channel pairs");
        end
        if (low_result_bits + fill_bits + flag_bits != byte_bits) begin
            $error("adc_result_registers low byte layout does not add up to one byte");
        end
        if (low_result_bits < 1) begin
            $error("adc_result_registers needs a result wider than one byte");
        end
        if (pairs > byte_bits) begin
            $error("adc_result_registers status byte cannot hold every pair");
        end
        if (pair2_high_addr == pair2_low_addr || pair3_high_addr == pair3_low_addr) begin
            $error("adc_result_registers result bytes of a pair must differ");
        end
        if (pair2_low_addr == pair3_low_addr || pair2_high_addr == pair3_high_addr) begin
            $error("adc_result_registers pairs must not share result bytes");
        end
        if (irq_status_addr == irq_mask_addr) begin
            $error("adc_result_registers status and mask must not share an address");
        end
        if (unmapped_value != {byte_bits{1'b0}}) begin
            $error("adc_result_registers idle read data must be zero for bus oring");
        end
    end

    logic [result_width-1:0] result [pairs];
    logic [pairs-1:0] stored_flag;
    logic [pairs-1:0] read_hit;
    logic [pairs-1:0] load;
    logic [pairs-1:0] irq_status;
    logic [pairs-1:0] irq_mask;
    logic [7:0] next_rdata;
    // Address decode per pair and byte
    logic [pairs-1:0] low_hit;
    logic [pairs-1:0] high_hit;
    // Bytes as software will see them, one pair each
    logic [7:0] low_view [pairs];
    logic [7:0] high_view [pairs];
    // Write side decode and next values of the status logic
    logic status_write;
    logic mask_write;
    logic [pairs-1:0] status_clear;
    logic [pairs-1:0] next_irq_status;
    logic [pairs-1:0] pending;
    logic next_irq;

    // Low byte address of a pair index
    function automatic logic [7:0] low_addr(input int idx);
        return (idx == 0) ? pair2_low_addr : pair3_low_addr;
    endfunction

    // High byte address of a pair index
    function automatic logic [7:0] high_addr(input int idx);
        return (idx == 0) ? pair2_high_addr : pair3_high_addr;
    endfunction

    // Low result byte: lowest result bits on top, fixed ones, flag at the bottom
    function automatic logic [7:0] low_byte(input logic [result_width-1:0] res, input logic flag);
        return {res[low_result_bits-1:0], low_fill_ones, flag};
    endfunction

    // High result byte: the upper result bits
    function automatic logic [7:0] high_byte(input logic [result_width-1:0] res);
        return res[result_width-1:low_result_bits];
    endfunction

    // Per-pair bits padded with zeros to one bus byte
    function automatic logic [7:0] pair_byte(input logic [pairs-1:0] bits);
        return {{status_pad{1'b0}}, bits};
    endfunction

    // One storage slot per channel pair
    genvar g;
    generate
        for (g = 0; g < pairs; g++) begin : slot
            // read of either byte
            // Byte decode for this pair
            assign low_hit[g] = bus.addr == low_addr(g);
            assign high_hit[g] = bus.addr == high_addr(g);
            assign read_hit[g] = bus.rd && (low_hit[g] || high_hit[g]);
            assign load[g] = conv.valid && (conv.pair == 1'(g));
            assign low_view[g] = low_byte(result[g], stored_flag[g]);
            assign high_view[g] = high_byte(result[g]);
            // Event waiting and enabled for this pair
            assign pending[g] = irq_status[g] & irq_mask[g];

            result_slot #(
                .width(result_width)
            ) u_slot (
                .clk(clk),
                .srst(srst),
                .load(load[g]),
                .value(conv.value),
                .read_hit(read_hit[g]),
                .result(result[g]),
                .stored_result_flag(stored_flag[g])
            );
        end
    endgenerate

    // Read mux; writes to result bytes are ignored since they are read-only
    // byte split of result
    always_comb begin
        next_rdata = unmapped_value;
        case (bus.addr)
            pair2_low_addr: next_rdata = low_view[0];
            pair2_high_addr: next_rdata = high_view[0];
            pair3_low_addr: next_rdata = low_view[1];
            pair3_high_addr: next_rdata = high_view[1];
            irq_status_addr: next_rdata = pair_byte(irq_status);
            irq_mask_addr: next_rdata = pair_byte(irq_mask);
            default: next_rdata = unmapped_value;
        endcase
    end

    // Read data registered, valid the cycle after the strobe
    // Zero outside that cycle so a stale byte is never mistaken for a new one
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= unmapped_value;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= unmapped_value;
        end
    end

    // Write decode; writes to the result bytes match nothing and are dropped
    assign status_write = bus.wr && bus.addr == irq_status_addr;
    assign mask_write = bus.wr && bus.addr == irq_mask_addr;

    // Write-one-to-clear bits, all zero when no status write is present
    assign status_clear = status_write ? bus.wdata[pairs-1:0] : {pairs{1'b0}};

    // A new store wins over a clear of the same bit, so no event is lost
    assign next_irq_status = load | (irq_status & ~status_clear);

    // Interrupt request before the output flop
    assign next_irq = |pending;

    // Sticky store events
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_status <= flags_reset;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Interrupt mask, one bit enables the matching status bit
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_mask <= mask_reset;
        end else if (mask_write) begin
            irq_mask <= bus.wdata[pairs-1:0];
        end
    end

    // Level interrupt from a flop; lags status by one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end
endmodule

//--- tb/adc_result_checker.sv
// Port checker for the conversion result registers
`timescale 1ns/100ps
module adc_result_checker
    import adc_result_pkg::*;
(
    // Watched ports
    input wire logic clk,
    input wire logic srst,
    input wire conv_result_s conv,
    input wire bus_req_s bus,
    input wire logic [7:0] rdata,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Pair 2/6 store, idle gap, then a read
    sequence st_rd(logic [7:0] a);
        conv.valid && !conv.pair ##1 !bus.rd ##1 bus.rd && bus.addr == a;
    endsequence
    AST_FILL: assert property (bus.rd && bus.addr[7:2] == 6'h19 && !bus.addr[0] |=> rdata[5:1] == 5'h1f)
        else $error("low byte fill bits not one");
    AST_SET: assert property (st_rd(8'h64) |=> rdata == {$past(conv.value[1:0], 3), 6'h3f})
        else $error("low byte wrong after store");
    AST_HIGH: assert property (st_rd(8'h65) |=> rdata == $past(conv.value[9:2], 3))
        else $error("high byte wrong after store");
    AST_CLR: assert property (bus.rd && bus.addr == 8'h65 && !conv.valid ##1 !bus.rd && !conv.valid
        ##1 bus.rd && bus.addr == 8'h64 |=> !rdata[0])
        else $error("flag kept after high read");
    AST_FLAG: assert property (bus.rd && bus.addr == 8'h64 && !conv.valid ##1 !bus.rd && !conv.valid
        ##1 bus.rd && bus.addr == 8'h64 |=> !rdata[0])
        else $error("flag kept after low read");
    AST_RST: assert property (disable iff (1'b0) srst |=> !irq && rdata == 8'h00)
        else $error("outputs not cleared by reset");
    // Masking everything drops the line one edge later; checked at the second edge
    AST_MASK: assert property (bus.wr && bus.addr == 8'h69 && bus.wdata[1:0] == 2'h0 |-> ##2 !irq)
        else $error("interrupt high while fully masked");
endmodule
bind adc_result_registers adc_result_checker adc_result_checker_inst (.clk(clk), .srst(srst), .conv(conv),
    .bus(bus), .rdata(rdata), .irq(irq));

//--- tb/adc_result_registers_test.sv
// Self-checking bench for the conversion result registers
`timescale 1ns/100ps
module adc_result_registers_test;
    import adc_result_pkg::*;
    logic clk = 0, srst = 1, irq;
    logic [7:0] rdata;
    conv_result_s conv = '0;
    bus_req_s bus = '0;
    logic [9:0] res [2];
    logic [1:0] flg = 0, st = 0, msk = 0;
    int n_fail = 0, total_checks = 0, i;
    adc_result_registers adc_result_registers_inst (.clk(clk), .srst(srst), .conv(conv), .bus(bus),
        .rdata(rdata), .irq(irq));
    always #2.5 clk = ~clk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Expected read value from the bench's own copy of the registers
    function automatic logic [7:0] expv(input logic [7:0] a);
        case (a)
            8'h64, 8'h66: return {res[a[1]][1:0], 5'h1f, flg[a[1]]};
            8'h65, 8'h67: return res[a[1]][9:2];
            8'h68: return {6'h00, st};
            8'h69: return {6'h00, msk};
            default: return 8'h00;
        endcase
    endfunction
    // One strobe cycle, released at the next edge
    task automatic cyc(input bus_req_s b, input conv_result_s c);
        @(posedge clk);
        bus <= b;
        conv <= c;
        @(posedge clk);
        bus <= '0;
        conv <= '0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = expv(a);
        cyc('{a, 8'h00, 1'b0, 1'b1}, '0);
        if (a[7:2] == 6'h19) flg[a[1]] = 0;
        chk(rdata, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc('{a, d, 1'b1, 1'b0}, '0);
        if (a == 8'h68) st = st & ~d[1:0];
        if (a == 8'h69) msk = d[1:0];
    endtask
    task automatic cv(input logic p, input logic [9:0] v);
        cyc('0, '{1'b1, p, v});
        res[p] = v;
        flg[p] = 1;
        st[p] = 1;
    endtask
    // Interrupt settles one edge after its cause; checked after the second edge
    task automatic ck();
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, irq}, {7'h00, |(st & msk)});
    endtask
    task automatic results();
        if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Random stores, masks, reads and clears
    initial begin
        i = $urandom(32'hbd78);
        res[0] = 0;
        res[1] = 0;
        repeat (6) @(posedge clk);
        srst <= 0;
        rd(8'h64);
        rd(8'h6a);
        for (i = 0; i < 40; i++) begin
            if (i % 3 == 0) cv(i[0], 10'($urandom));
            cv(i[0], 10'($urandom));
            rd({6'h19, i[0], i[1]});
            rd({6'h19, i[0], 1'b0});
            wr(8'h69, 8'($urandom));
            ck();
            wr({6'h19, 2'($urandom)}, 8'($urandom));
            rd({6'h19, 2'($urandom)});
            rd(8'h68);
            wr(8'h68, 8'($urandom));
            ck();
        end
        results();
    end
    // Watchdog against a hung run
    initial begin
        #20000;
        n_fail++;
        results();
    end
endmodule
